// File: src/pdmc_clock_gate.sv
// module: registered clock enables for the cpu, peripherals and clock pin
`timescale 1ns/1ps
`default_nettype none
module pdmc_clock_gate import pdmc_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    pdmc_ctl_if.gate ctl,
    output logic [6:0] o_en
);
    logic [6:0] en_q;
    logic run;
    logic deep;
    logic standby;

    // ========================================================
    // mode decode
    assign run = (ctl.mode == PDMC_MODE_RUN);
    assign deep = (ctl.mode == PDMC_MODE_DEEP_SLEEP);
    assign standby = (ctl.mode == PDMC_MODE_STANDBY);

    // ========================================================
    // enables, one cycle behind mode and stop bits
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            en_q <= PDMC_EN_RESET;
        end else if (i_ce) begin
            en_q[PDMC_EN_CPU] <= run;
            // clock pin stops only in standby
            en_q[PDMC_EN_CLOCK_OUTPUT] <= !standby;
            // dma clock stop, also halted in deep sleep
            en_q[PDMC_EN_DMA] <= !ctl.stop[PDMC_BIT_DMA_CLOCK_STOP]
                && !standby && !deep;
            // per-module clock stops, cleared bit restores
            en_q[PDMC_EN_FIFO_SERIAL] <=
                !ctl.stop[PDMC_BIT_FIFO_SERIAL_CLOCK_STOP] && !standby;
            en_q[PDMC_EN_TIMER_UNIT] <=
                !ctl.stop[PDMC_BIT_TIMER_UNIT_CLOCK_STOP] && !standby;
            en_q[PDMC_EN_FIRST_SERIAL] <=
                !ctl.stop[PDMC_BIT_FIRST_SERIAL_CLOCK_STOP] && !standby;
            // only the rtc bus clock; its counters run on their own
            en_q[PDMC_EN_RTC_BUS] <=
                !ctl.stop[PDMC_BIT_REALTIME_CLOCK_STOP] && !standby;
        end
    end

    assign o_en = en_q;
endmodule // pdmc_clock_gate
`default_nettype wire

// File: src/pdmc_ctl_if.sv
// interface: power mode and module clock stop bits toward the clock gate
`timescale 1ns/1ps
`default_nettype none
interface pdmc_ctl_if import pdmc_pkg::*; ();
    pdmc_mode_t mode;
    logic [PDMC_STOP_WIDTH-1:0] stop;

    modport ctl (output mode, output stop);
    modport gate (input mode, input stop);
endinterface
`default_nettype wire

// File: src/pdmc_pkg.sv
// package: power-down mode control register map, field positions and modes
package pdmc_pkg;
    // ========================================================
    // register map (byte addresses, one aligned word each)
    localparam logic [31:0] PDMC_ADDR_STANDBY_CONTROL = 32'hffc00004;
    localparam logic [31:0] PDMC_ADDR_STANDBY_CONTROL_TWO = 32'hffc00010;
    localparam logic [31:0] PDMC_ADDR_MODE_STATUS = 32'hffc00020;
    // one-hot register selects out of the address decoder
    localparam logic [2:0] PDMC_SEL_NONE = 3'h0;
    localparam logic [2:0] PDMC_SEL_CONTROL = 3'h1;
    localparam logic [2:0] PDMC_SEL_CONTROL_TWO = 3'h2;
    localparam logic [2:0] PDMC_SEL_STATUS = 3'h4;

    // ========================================================
    // reset values and masks
    localparam logic [7:0] PDMC_CONTROL_RESET = 8'h00;
    localparam logic [7:0] PDMC_CONTROL_TWO_RESET = 8'h00;
    localparam logic [7:0] PDMC_CONTROL_TWO_WMASK = 8'h80;

    // ========================================================
    // field positions in standby_control / standby_control_two
    localparam int PDMC_BIT_STANDBY_SELECT = 7;
    localparam int PDMC_BIT_PIN_HIZ_IN_STANDBY = 6;
    localparam int PDMC_BIT_PIN_PULLUP_DISABLE = 5;
    localparam int PDMC_BIT_DMA_CLOCK_STOP = 4;
    localparam int PDMC_BIT_FIFO_SERIAL_CLOCK_STOP = 3;
    localparam int PDMC_BIT_TIMER_UNIT_CLOCK_STOP = 2;
    localparam int PDMC_BIT_REALTIME_CLOCK_STOP = 1;
    localparam int PDMC_BIT_FIRST_SERIAL_CLOCK_STOP = 0;
    localparam int PDMC_BIT_DEEP_SLEEP_SELECT = 7;
    localparam int PDMC_STOP_WIDTH = 5;

    // ========================================================
    // clock enable vector layout and its value after reset
    localparam int PDMC_EN_FIRST_SERIAL = 0;
    localparam int PDMC_EN_RTC_BUS = 1;
    localparam int PDMC_EN_TIMER_UNIT = 2;
    localparam int PDMC_EN_FIFO_SERIAL = 3;
    localparam int PDMC_EN_DMA = 4;
    localparam int PDMC_EN_CPU = 5;
    localparam int PDMC_EN_CLOCK_OUTPUT = 6;
    localparam logic [6:0] PDMC_EN_RESET = 7'h7f;

    // ========================================================
    // pin synchroniser layout: {manual_reset_n, irl, nmi}
    localparam int PDMC_PIN_NMI = 0;
    localparam int PDMC_PIN_IRL = 1;
    localparam int PDMC_PIN_MANUAL_RESET_N = 2;
    localparam logic [2:0] PDMC_PIN_SYNC_RESET = 3'h4;

    // ========================================================
    // bus constants
    localparam int PDMC_HTRANS_ACTIVE_BIT = 1;

    // power modes, one-hot
    typedef enum logic [3:0] {
        PDMC_MODE_RUN = 4'h1,
        PDMC_MODE_SLEEP = 4'h2,
        PDMC_MODE_DEEP_SLEEP = 4'h4,
        PDMC_MODE_STANDBY = 4'h8
    } pdmc_mode_t;
endpackage

// File: src/pdmc_power_down_ctl.sv
// module: power-down mode controller with ahb-lite register slave
//
// Behaviour
// - halt with standby select 0 and no deep sleep enters sleep
// - halt with standby select 1 enters standby
// - halt with standby select 0 and deep sleep select 1 enters deep sleep
// - in sleep peripherals and clock output pin keep running
// - standby halts peripherals, cpu and clock output pin
// - nmi, irl, peripheral interrupt or reset leave the low power mode
// - pin hiz bit set floats peripheral pins during standby
// - pull-up disable bit 0 turns peripheral pin pull-ups on
// - control registers are 8 bit, cleared by reset or watchdog overflow
// - dma clock stop bit stops the dma controller clock
// - rtc stop bit stops rtc bus clock, counters keep counting
// - fifo serial, timer unit, first serial stop bits stop their clocks
// - both control registers mapped at their documented addresses
`timescale 1ns/1ps
`default_nettype none
module pdmc_power_down_ctl import pdmc_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    input wire logic i_halt_exec,
    input wire logic i_periph_irq,
    input wire logic i_wdt_overflow,
    input wire logic i_nmi,
    input wire logic i_irl_req,
    input wire logic i_manual_reset_n,
    output logic o_cpu_clk_en,
    output logic o_dma_clk_en,
    output logic o_fifo_serial_clk_en,
    output logic o_timer_unit_clk_en,
    output logic o_rtc_bus_clk_en,
    output logic o_first_serial_clk_en,
    output logic o_clock_output_en,
    output logic o_pin_hiz,
    output logic o_pin_pullup_en,
    output logic [3:0] o_mode,
    output logic o_wake_exception
);
    pdmc_ctl_if ctl_if ();

    logic bus_take;
    logic [2:0] sel_addr;
    logic wr_pend_q;
    logic [2:0] wr_sel_q;
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    logic [7:0] two_q;
    logic [7:0] two_d;
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;
    pdmc_mode_t mode_q;
    pdmc_mode_t mode_d;
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic [2:0] s3_q;
    logic [2:0] pin_q;
    logic wake_irq;
    logic wake_rst;
    logic wake_exc_q;
    logic pin_hiz_q;
    logic [6:0] en;

    // ========================================================
    // address decode, whole word aligned compare
    function automatic logic [2:0] reg_decode(input logic [31:0] a);
        if (a[31:2] == PDMC_ADDR_STANDBY_CONTROL[31:2]) begin
            reg_decode = PDMC_SEL_CONTROL;
        end else if (a[31:2] == PDMC_ADDR_STANDBY_CONTROL_TWO[31:2]) begin
            reg_decode = PDMC_SEL_CONTROL_TWO;
        end else if (a[31:2] == PDMC_ADDR_MODE_STATUS[31:2]) begin
            reg_decode = PDMC_SEL_STATUS;
        end else begin
            reg_decode = PDMC_SEL_NONE;
        end
    endfunction

    // ========================================================
    // ahb-lite slave, zero wait states, always okay
    assign bus_take = i_hsel && i_htrans[PDMC_HTRANS_ACTIVE_BIT] && i_hready;
    assign sel_addr = reg_decode(i_haddr);
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_hrdata = hrdata_q;

    // address phase captured; write performed in the data phase
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_pend_q <= 1'b0;
            wr_sel_q <= PDMC_SEL_NONE;
        end else if (i_ce) begin
            wr_pend_q <= bus_take && i_hwrite;
            wr_sel_q <= sel_addr;
        end
    end

    // ========================================================
    // register next values; watchdog overflow beats a pending write
    always_comb begin
        ctl_d = ctl_q;
        two_d = two_q;
        if (i_wdt_overflow) begin
            ctl_d = PDMC_CONTROL_RESET;
            two_d = PDMC_CONTROL_TWO_RESET;
        end else if (wr_pend_q && wr_sel_q == PDMC_SEL_CONTROL) begin
            // byte lane 0 of the word
            ctl_d = i_hwdata[7:0];
        end else if (wr_pend_q && wr_sel_q == PDMC_SEL_CONTROL_TWO) begin
            // reserved bits stay zero whatever is written
            two_d = i_hwdata[7:0] & PDMC_CONTROL_TWO_WMASK;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctl_q <= PDMC_CONTROL_RESET;
            two_q <= PDMC_CONTROL_TWO_RESET;
        end else if (i_ce) begin
            ctl_q <= ctl_d;
            two_q <= two_d;
        end
    end

    // read data uses next values so a write followed by a read of
    // the same register returns the new byte without a wait state
    always_comb begin
        hrdata_d = 32'h0000_0000;
        if (sel_addr == PDMC_SEL_CONTROL) begin
            hrdata_d = {24'h00_0000, ctl_d};
        end else if (sel_addr == PDMC_SEL_CONTROL_TWO) begin
            hrdata_d = {24'h00_0000, two_d};
        end else if (sel_addr == PDMC_SEL_STATUS) begin
            hrdata_d = {28'h000_0000, mode_q};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hrdata_q <= 32'h0000_0000;
        end else if (i_ce && bus_take && !i_hwrite) begin
            hrdata_q <= hrdata_d;
        end
    end

    // ========================================================
    // pin synchronisers: three stages, change taken when 2 and 3 agree
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s1_q <= PDMC_PIN_SYNC_RESET;
            s2_q <= PDMC_PIN_SYNC_RESET;
            s3_q <= PDMC_PIN_SYNC_RESET;
            pin_q <= PDMC_PIN_SYNC_RESET;
        end else if (i_ce) begin
            s1_q <= {i_manual_reset_n, i_irl_req, i_nmi};
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= (s2_q & ~(s2_q ^ s3_q)) | (pin_q & (s2_q ^ s3_q));
        end
    end

    // interrupt sources wake with exception handling; resets just wake
    assign wake_irq = pin_q[PDMC_PIN_NMI] || pin_q[PDMC_PIN_IRL]
        || i_periph_irq;
    assign wake_rst = !pin_q[PDMC_PIN_MANUAL_RESET_N] || i_wdt_overflow;

    // ========================================================
    // power mode state machine
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            PDMC_MODE_RUN: begin
                if (i_halt_exec) begin
                    if (ctl_q[PDMC_BIT_STANDBY_SELECT]) begin
                        // standby select wins over deep sleep
                        mode_d = PDMC_MODE_STANDBY;
                    end else if (two_q[PDMC_BIT_DEEP_SLEEP_SELECT]) begin
                        mode_d = PDMC_MODE_DEEP_SLEEP;
                    end else begin
                        mode_d = PDMC_MODE_SLEEP;
                    end
                end
            end
            PDMC_MODE_SLEEP, PDMC_MODE_DEEP_SLEEP, PDMC_MODE_STANDBY: begin
                if (wake_irq || wake_rst) begin
                    mode_d = PDMC_MODE_RUN;
                end
            end
            default: begin
                mode_d = PDMC_MODE_RUN;
            end
        endcase
        // a watchdog reset always lands in run
        if (i_wdt_overflow) begin
            mode_d = PDMC_MODE_RUN;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mode_q <= PDMC_MODE_RUN;
        end else if (i_ce) begin
            mode_q <= mode_d;
        end
    end

    // one-cycle pulse asks the cpu for exception handling
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wake_exc_q <= 1'b0;
        end else if (i_ce) begin
            wake_exc_q <= (mode_q != PDMC_MODE_RUN) && wake_irq && !wake_rst;
        end
    end

    // ========================================================
    // pin control
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pin_hiz_q <= 1'b0;
        end else if (i_ce) begin
            // float pins only in standby and only when asked
            pin_hiz_q <= (mode_q == PDMC_MODE_STANDBY)
                && ctl_q[PDMC_BIT_PIN_HIZ_IN_STANDBY];
        end
    end

    // pull-ups on while the disable bit is clear
    assign o_pin_pullup_en = !ctl_q[PDMC_BIT_PIN_PULLUP_DISABLE];
    assign o_pin_hiz = pin_hiz_q;
    assign o_mode = mode_q;
    assign o_wake_exception = wake_exc_q;

    // ========================================================
    // clock gate
    assign ctl_if.mode = mode_q;
    assign ctl_if.stop = ctl_q[PDMC_STOP_WIDTH-1:0];

    pdmc_clock_gate pdmc_clock_gate_inst (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .ctl(ctl_if.gate),
        .o_en(en)
    );
    assign o_cpu_clk_en = en[PDMC_EN_CPU];
    assign o_dma_clk_en = en[PDMC_EN_DMA];
    assign o_fifo_serial_clk_en = en[PDMC_EN_FIFO_SERIAL];
    assign o_timer_unit_clk_en = en[PDMC_EN_TIMER_UNIT];
    assign o_rtc_bus_clk_en = en[PDMC_EN_RTC_BUS];
    assign o_first_serial_clk_en = en[PDMC_EN_FIRST_SERIAL];
    assign o_clock_output_en = en[PDMC_EN_CLOCK_OUTPUT];

    // ========================================================
    // checks; a frozen clock enable aborts any attempt in flight
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst || !i_ce);
    sequence s_halt_run;
        mode_q == PDMC_MODE_RUN && i_halt_exec && !i_wdt_overflow;
    endsequence
    sequence s_write_control;
        wr_pend_q && wr_sel_q == PDMC_SEL_CONTROL && !i_wdt_overflow;
    endsequence
    AST_SLEEP_ENTRY: assert property (
        s_halt_run ##0 (!ctl_q[PDMC_BIT_STANDBY_SELECT]
        && !two_q[PDMC_BIT_DEEP_SLEEP_SELECT])
        |=> mode_q == PDMC_MODE_SLEEP ##1 !o_cpu_clk_en)
        else $error("halt did not enter sleep");
    AST_STANDBY_ENTRY: assert property (
        s_halt_run ##0 ctl_q[PDMC_BIT_STANDBY_SELECT]
        |=> mode_q == PDMC_MODE_STANDBY)
        else $error("halt did not enter standby");
    AST_DEEP_ENTRY: assert property (
        s_halt_run ##0 (!ctl_q[PDMC_BIT_STANDBY_SELECT]
        && two_q[PDMC_BIT_DEEP_SLEEP_SELECT])
        |=> mode_q == PDMC_MODE_DEEP_SLEEP ##1 !o_dma_clk_en)
        else $error("halt did not enter deep sleep");
    AST_SLEEP_RUNS: assert property (
        (mode_q == PDMC_MODE_SLEEP && !ctl_q[PDMC_BIT_TIMER_UNIT_CLOCK_STOP])
        [*2] |-> o_clock_output_en && o_timer_unit_clk_en && !o_cpu_clk_en)
        else $error("sleep stopped a peripheral or the clock pin");
    AST_STANDBY_HALTS: assert property (
        (mode_q == PDMC_MODE_STANDBY) [*2] |-> !o_clock_output_en
        && !o_timer_unit_clk_en && !o_first_serial_clk_en && !o_cpu_clk_en)
        else $error("standby left a clock running");
    AST_WAKE: assert property (
        mode_q != PDMC_MODE_RUN && wake_irq && !wake_rst
        |=> mode_q == PDMC_MODE_RUN && o_wake_exception ##1 o_cpu_clk_en)
        else $error("interrupt did not wake with exception");
    AST_PIN_HIZ: assert property (
        mode_q == PDMC_MODE_STANDBY ##1 $stable(mode_q)
        |-> o_pin_hiz == $past(ctl_q[PDMC_BIT_PIN_HIZ_IN_STANDBY]))
        else $error("pin hiz does not follow standby and its bit");
    AST_NO_HIZ_AWAKE: assert property (
        mode_q != PDMC_MODE_STANDBY |=> !o_pin_hiz)
        else $error("pins floated outside standby");
    AST_PULLUP: assert property (
        s_write_control |=> o_pin_pullup_en
        == !$past(i_hwdata[PDMC_BIT_PIN_PULLUP_DISABLE]))
        else $error("pull-up does not follow written bit");
    AST_WDT_CLEAR: assert property (
        i_wdt_overflow |=> ctl_q == PDMC_CONTROL_RESET
        && two_q == PDMC_CONTROL_TWO_RESET && mode_q == PDMC_MODE_RUN)
        else $error("watchdog overflow did not clear registers");
    AST_DMA_STOP: assert property (
        ctl_q[PDMC_BIT_DMA_CLOCK_STOP] |=> !o_dma_clk_en)
        else $error("dma clock runs while stopped");
    AST_RTC_STOP: assert property (
        ctl_q[PDMC_BIT_REALTIME_CLOCK_STOP] |=> !o_rtc_bus_clk_en)
        else $error("rtc bus clock runs while stopped");
    AST_MODULE_STOPS: assert property (
        ctl_q[PDMC_BIT_FIFO_SERIAL_CLOCK_STOP]
        && ctl_q[PDMC_BIT_FIRST_SERIAL_CLOCK_STOP]
        |=> !o_fifo_serial_clk_en && !o_first_serial_clk_en)
        else $error("serial clock runs while stopped");
    AST_READBACK: assert property (
        bus_take && !i_hwrite && sel_addr == PDMC_SEL_CONTROL
        |=> o_hrdata == {24'h00_0000, ctl_q})
        else $error("read returned stale data");
    AST_RESTORE: assert property (
        $fell(ctl_q[PDMC_BIT_TIMER_UNIT_CLOCK_STOP])
        && mode_q == PDMC_MODE_RUN |=> o_timer_unit_clk_en)
        else $error("timer unit clock not restored");
endmodule // pdmc_power_down_ctl
`default_nettype wire

// File: testbench/pdmc_far_model.sv
// partner model: cpu halt strobe, peripheral interrupt and a gated timer
`timescale 1ns/1ps
`default_nettype none
module pdmc_far_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_halt_req,
    input wire logic i_irq_req,
    input wire logic [3:0] i_mode,
    input wire logic i_timer_clk_en,
    output logic o_halt_exec,
    output logic o_periph_irq,
    output logic [7:0] o_ticks
);
    // ========================================================
    // cpu side
    // no dma in flight: this cpu never starts a transfer
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_halt_exec <= 1'b0;
        end else begin
            o_halt_exec <= i_halt_req & ~o_halt_exec; // one pulse
        end
    end

    // interrupt stays pending until the controller is back in run
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_periph_irq <= 1'b0;
        end else if (i_irq_req) begin
            o_periph_irq <= 1'b1;
        end else if (i_mode == 4'h1) begin
            o_periph_irq <= 1'b0;
        end
    end

    // ========================================================
    // timer: counts only on edges its gated clock would deliver
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_ticks <= 8'h00;
        end else if (i_timer_clk_en) begin
            o_ticks <= o_ticks + 8'h01;
        end
    end
endmodule // pdmc_far_model
`default_nettype wire

// File: testbench/pdmc_power_down_ctl_test.sv
// testbench: register, mode and clock gate checks of the power-down block
`timescale 1ns/1ps
`default_nettype none
module pdmc_power_down_ctl_test import pdmc_pkg::*; ;
    logic i_clk = 0, i_rst = 1, hsel = 0, hwrite = 0, wdt = 0;
    logic nmi = 0, external_interrupt_level = 0, mrst_n = 1, halt_req = 0, irq_req = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd;
    logic [1:0] htrans = 0;
    wire logic hready, hresp, halt_exec, periph_irq, cpu_en, dma_en, fifo_en;
    wire logic tmr_en, rtc_en, ser_en, out_en, hiz, pu_en, wake;
    wire logic [31:0] hrdata;
    wire logic [3:0] mode;
    wire logic [7:0] ticks;
    wire logic [31:0] en;
    int failures = 0, tests_run = 0;
    // halt table: control, control two, expected mode
    logic [7:0] t_ctl [5] = '{8'h40, 8'h40, 8'hc0, 8'h00, 8'h80};
    logic [7:0] t_two [5] = '{8'h00, 8'h80, 8'h80, 8'h00, 8'h00};
    logic [3:0] t_mode [5] = '{PDMC_MODE_SLEEP, PDMC_MODE_DEEP_SLEEP,
                               PDMC_MODE_STANDBY, PDMC_MODE_SLEEP,
                               PDMC_MODE_STANDBY};

    assign en = {25'h0, out_en, cpu_en, dma_en, fifo_en, tmr_en, rtc_en,
                 ser_en};

    // 250 MHz clock
    always #2 i_clk = ~i_clk;

    pdmc_power_down_ctl pdmc_power_down_ctl_inst (.i_clk(i_clk), .i_rst(i_rst),
        .i_ce(1'b1), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready),
        .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
        .i_halt_exec(halt_exec), .i_periph_irq(periph_irq),
        .i_wdt_overflow(wdt), .i_nmi(nmi), .i_irl_req(external_interrupt_level),
        .i_manual_reset_n(mrst_n), .o_cpu_clk_en(cpu_en),
        .o_dma_clk_en(dma_en),
        .o_fifo_serial_clk_en(fifo_en), .o_timer_unit_clk_en(tmr_en),
        .o_rtc_bus_clk_en(rtc_en), .o_first_serial_clk_en(ser_en),
        .o_clock_output_en(out_en), .o_pin_hiz(hiz), .o_pin_pullup_en(pu_en),
        .o_mode(mode), .o_wake_exception(wake));

    pdmc_far_model pdmc_far_model_inst (.i_clk(i_clk), .i_rst(i_rst),
        .i_halt_req(halt_req), .i_irq_req(irq_req), .i_mode(mode),
        .i_timer_clk_en(tmr_en), .o_halt_exec(halt_exec),
        .o_periph_irq(periph_irq), .o_ticks(ticks));

    // ========================================================
    // compare helpers
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (e !== g) begin
            $display("BAD %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask

    task automatic chk1(input string n, input logic e, input logic g);
        chk(n, {31'h0, e}, {31'h0, g});
    endtask

    // wait n edges, then sample where outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // single ahb-lite transfer; only the bench watchdog ends a wait
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] r);
        @(posedge i_clk);
        chk1("hready idle", 1'b1, hready);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge i_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge i_clk); while (hready !== 1'b1);
        r = hrdata;
        chk1("hresp", 1'b0, hresp);
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ========================================================
    // main sequence
    initial begin : main
        logic [7:0] t0;
        logic [3:0] m;
        logic sb, seen;
        int k, n;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        cyc(1);
        bus(0, PDMC_ADDR_STANDBY_CONTROL, 0, rd);
        chk("control reset", 32'h0, rd);
        bus(0, PDMC_ADDR_STANDBY_CONTROL_TWO, 0, rd);
        chk("two reset", 32'h0, rd);
        chk("enables reset", 32'h7f, en);
        chk1("pullup reset", 1'b1, pu_en);
        // each stop bit alone, the cpu keeps running
        for (k = 0; k < 5; k++) begin
            bus(1, PDMC_ADDR_STANDBY_CONTROL, 32'h1 << k, rd);
            cyc(2);
            chk("stops", ~(32'h1 << k) & 32'h1f, en & 32'h1f);
            chk1("cpu runs", 1'b1, cpu_en);
        end
        bus(1, PDMC_ADDR_STANDBY_CONTROL, 0, rd);
        cyc(2);
        chk("restored", 32'h7f, en);
        // byte-wide registers, reserved bits, unmapped hole
        bus(1, PDMC_ADDR_STANDBY_CONTROL, 32'habcdef20, rd);
        bus(0, PDMC_ADDR_STANDBY_CONTROL, 0, rd);
        chk("control byte", 32'h20, rd);
        chk1("pullup off", 1'b0, pu_en);
        bus(1, PDMC_ADDR_STANDBY_CONTROL_TWO, 32'hff, rd);
        bus(0, PDMC_ADDR_STANDBY_CONTROL_TWO, 0, rd);
        chk("two reserved", 32'h80, rd);
        bus(1, 32'hffc00008, 32'hff, rd);
        bus(0, 32'hffc00008, 0, rd);
        chk("unmapped", 32'h0, rd);
        // watchdog overflow clears both registers
        bus(1, PDMC_ADDR_STANDBY_CONTROL, 32'h3f, rd);
        wdt <= 1'b1;
        cyc(1);
        wdt <= 1'b0;
        cyc(2);
        chk("enables after wdt", 32'h7f, en);
        bus(0, PDMC_ADDR_STANDBY_CONTROL, 0, rd);
        chk("control after wdt", 32'h0, rd);
        bus(0, PDMC_ADDR_STANDBY_CONTROL_TWO, 0, rd);
        chk("two after wdt", 32'h0, rd);
        // halt into each mode, wake by peripheral interrupt, nmi, irl and manual reset
        for (k = 0; k < 5; k++) begin
            bus(1, PDMC_ADDR_STANDBY_CONTROL, {24'h0, t_ctl[k]}, rd);
            bus(1, PDMC_ADDR_STANDBY_CONTROL_TWO, {24'h0, t_two[k]}, rd);
            cyc(2);
            halt_req <= 1'b1;
            cyc(1);
            halt_req <= 1'b0;
            cyc(5);
            m = t_mode[k];
            sb = m[3];
            chk("mode", {28'h0, m}, {28'h0, mode});
            chk1("cpu halted", 1'b0, cpu_en);
            chk1("clock out", !sb, out_en);
            chk1("dma clock", m[1], dma_en);
            chk1("pins float", sb & t_ctl[k][6], hiz);
            t0 = ticks;
            cyc(4);
            chk("timer ticks", sb ? 32'h0 : 32'h4,
                {24'h0, ticks - t0});
            bus(0, PDMC_ADDR_MODE_STATUS, 0, rd);
            chk("mode status", {28'h0, m}, rd);
            case (k)
                0: irq_req <= 1'b1;
                1: nmi <= 1'b1;
                2: external_interrupt_level <= 1'b1;
                default: mrst_n <= 1'b0;
            endcase
            seen = 1'b0;
            for (n = 0; n < 20 && mode !== 4'h1; n++) begin
                cyc(1);
                if (wake === 1'b1) begin
                    seen = 1'b1;
                end
            end
            irq_req <= 1'b0;
            nmi <= 1'b0;
            external_interrupt_level <= 1'b0;
            mrst_n <= 1'b1;
            chk("woken", 32'h1, {28'h0, mode});
            chk1("wake exception", k < 3, seen);
            cyc(2);
            chk1("cpu clock back", 1'b1, cpu_en);
            cyc(8);
        end
        summarize();
    end

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin : watchdog
        repeat (20000) @(posedge i_clk);
        $display("BAD run time expected end seen timeout");
        failures++;
        summarize();
    end
endmodule // pdmc_power_down_ctl_test
`default_nettype wire
